// [verification/hprs_axis_model.sv]
// Purpose: Motor, encoder and proximity dog switch behind the sequencer
// Assumes: One step every period_in+1 cycles while run_in is high
// Notes: Z marks every 16 units and stays high 4 cycles
`timescale 1ns/1ns
module hprs_axis_model (
  // Clock and control
  input wire logic clk_in,
  input wire logic clr_in,
  input wire logic run_in,
  input wire logic dir_dec_in,
  input wire logic [3:0] period_in,
  // Dog placement and pin polarity
  input wire logic signed [31:0] dog_lo_in,
  input wire logic signed [31:0] dog_hi_in,
  input wire logic dog_pol_in,
  // Pins
  output logic step_out,
  output logic dog_pin_out,
  output logic zphase_pin_out
);
  logic signed [31:0] pos_reg;
  logic signed [31:0] pos_next;
  logic [3:0] tick_reg;
  logic [2:0] zhold_reg;
  logic on_dog;
  assign pos_next = dir_dec_in ? pos_reg - 32'sh1 : pos_reg + 32'sh1;
  // Axis moves one unit per step; a long period stands for a heavy load
  always @(posedge clk_in) begin
    step_out <= 1'b0;
    if (zhold_reg != 3'h0) zhold_reg <= zhold_reg - 3'h1;
    if (clr_in) begin
      pos_reg <= 32'sh0;
      tick_reg <= 4'h0;
      zhold_reg <= 3'h0;
    end else if (run_in && tick_reg >= period_in) begin
      tick_reg <= 4'h0;
      step_out <= 1'b1;
      pos_reg <= pos_next;
      if (pos_next[3:0] == 4'h0) zhold_reg <= 3'h4; // Wide enough for the 3-FF sync
    end else if (run_in) tick_reg <= tick_reg + 4'h1;
  end
  // Pin shows the active level only while the axis sits on the dog
  assign on_dog = pos_reg >= dog_lo_in && pos_reg <= dog_hi_in;
  assign dog_pin_out = dog_pol_in ? on_dog : !on_dog;
  assign zphase_pin_out = zhold_reg != 3'h0;
endmodule // hprs_axis_model

// [verification/test_hprs_seq.sv]
// Purpose: Self-checking bench for the home return sequencer
// Assumes: Dog spans units 20..83 away from start, Z every 16 units
// Notes: Shift counts are judged from the last reference pin edge
`timescale 1ns/1ns
module test_hprs_seq;
  import hprs_pkg::*;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic mode_sel = 1'b1;
  logic [4:0] psel = 5'h00;
  logic start = 1'b0;
  logic servo_on = 1'b0;
  logic [3:0] rtype = 4'h0;
  logic rdir = 1'b0;
  logic dpol = 1'b0;
  logic [15:0] hspd = 16'h0000;
  logic [15:0] cspd = 16'h0000;
  logic [31:0] shift = 32'h0;
  logic [31:0] post = 32'h0;
  logic [31:0] hdata = 32'h0;
  logic [15:0] acc = 16'h0000;
  logic [15:0] dcl = 16'h0000;
  logic clr = 1'b1;
  logic [3:0] period = 4'h8;
  logic signed [31:0] dog_lo = 32'sh14;
  logic signed [31:0] dog_hi = 32'sh53;
  logic step, dog_pin, zpin, run, dir_dec, done, valid, terr;
  logic [15:0] spd, acc_o, dec_o, last_spd;
  logic [31:0] pos;
  logic [31:0] rng = 32'h0000_37E2;
  logic use_z = 1'b1;
  logic z_d = 1'b0;
  logic dog_d = 1'b0;
  int steps_since = 0;
  int err_total = 0;
  int samples_checked = 0;
  logic [3:0] kinds [8] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA};

  always #5 clk_in = ~clk_in;

  hprs_seq u_hprs_seq (.clk_in(clk_in), .rstn_in(rstn_in),
    .operation_mode_select_line_in(mode_sel), .point_select_lines_in(psel),
    .start_in(start), .servo_on_in(servo_on), .home_return_type_setting_in(rtype),
    .home_return_dir_setting_in(rdir), .dog_polarity_setting_in(dpol),
    .home_return_speed_setting_in(hspd), .creep_speed_setting_in(cspd),
    .home_shift_distance_setting_in(shift), .post_dog_travel_setting_in(post),
    .home_position_data_setting_in(hdata), .pt1_accel_time_in(acc),
    .pt1_decel_time_in(dcl), .dog_pin_in(dog_pin), .zphase_pin_in(zpin),
    .step_in(step), .run_out(run), .dir_dec_out(dir_dec), .speed_out(spd),
    .accel_time_out(acc_o), .decel_time_out(dec_o), .current_position_out(pos),
    .home_complete_out(done), .coord_valid_out(valid), .type_error_out(terr));

  hprs_axis_model u_hprs_axis_model (.clk_in(clk_in), .clr_in(clr), .run_in(run),
    .dir_dec_in(dir_dec), .period_in(period), .dog_lo_in(dog_lo), .dog_hi_in(dog_hi),
    .dog_pol_in(dpol), .step_out(step), .dog_pin_out(dog_pin), .zphase_pin_out(zpin));

  // Steps since the Z rise or dog edge that the method measures from
  always @(posedge clk_in) begin
    z_d <= zpin;
    dog_d <= dog_pin;
    if (use_z ? (zpin && !z_d) : (dog_pin != dog_d)) steps_since <= 0;
    else if (step) steps_since <= steps_since + 1;
    if (step) last_spd <= spd;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Units travelled after the reference edge before home is declared
  function automatic logic [31:0] exp_steps(input logic [3:0] t, input logic [31:0] p, s);
    case (t)
      HPRS_TYPE_CRADLE: return 32'h0;
      HPRS_TYPE_REAR_END, HPRS_TYPE_CNT_FRONT, HPRS_TYPE_FRONT_END: return p + s;
      default: return s;
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_total++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic pulse_start;
    start = 1'b1;
    repeat (3) @(negedge clk_in);
    start = 1'b0;
    @(negedge clk_in);
  endtask

  // One full homing with random settings, slow or prompt axis
  task automatic home_run(input logic [3:0] t);
    int n;
    rng = xs(rng);
    rtype = t;
    rdir = rng[0];
    dpol = rng[1];
    period = 4'h8 + {1'b0, rng[4:2]};
    shift = {29'h0, rng[7:5]} + {29'h0, rng[10:8]};
    post = {27'h0, rng[15:11]};
    hspd = rng[31:16];
    cspd = ~rng[31:16];
    hdata = xs(rng);
    acc = hdata[15:0];
    dcl = hdata[31:16];
    servo_on = t == HPRS_TYPE_IGNORE ? rng[20] : 1'b1;
    dog_lo = rdir ? 32'shFFFF_FFAD : 32'sh14; // Mirror of 20..83 when decreasing
    dog_hi = rdir ? 32'shFFFF_FFEC : 32'sh53;
    use_z = !(t inside {HPRS_TYPE_REAR_END, HPRS_TYPE_CNT_FRONT, HPRS_TYPE_FRONT_END});
    clr = 1'b1;
    @(negedge clk_in);
    clr = 1'b0;
    // New polarity and cleared axis move the pin; let the filter settle first
    repeat (6) @(negedge clk_in);
    start = 1'b1;
    repeat (2) @(negedge clk_in);
    start = 1'b0;
    if (t == HPRS_TYPE_IGNORE) check({done, run}, {servo_on, 1'b0});
    else begin
      check(done, 1'b0);
      check(dir_dec, rdir);
      check(spd, t == HPRS_TYPE_DOGLESS_Z ? cspd : hspd);
      check({acc_o, dec_o}, {acc, dcl});
    end
    for (n = 0; n < 6000 && done !== 1'b1; n++) begin
      if (n == 20) servo_on = 1'b1;
      @(negedge clk_in);
    end
    check(done, 1'b1);
    check(pos, hdata);
    check({valid, run, spd}, 18'h20000);
    if (t != HPRS_TYPE_IGNORE) begin
      check(32'(steps_since), exp_steps(t, post, shift));
      // With no travel after the front end, the last step was still at home speed
      check(last_spd, (t inside {HPRS_TYPE_CNT_FRONT, HPRS_TYPE_FRONT_END}
        && post + shift == 32'h0) ? hspd : cspd);
    end
  endtask

  initial begin
    repeat (6) @(negedge clk_in);
    rstn_in = 1'b1;
    check({run, done, valid, terr}, 4'h0);
    check(pos, 32'h0);
    // Wrong mode lines must not start anything
    psel = 5'h01 << (rng % 5);
    pulse_start;
    check(run, 1'b0);
    psel = 5'h00;
    mode_sel = 1'b0;
    pulse_start;
    check(run, 1'b0);
    mode_sel = 1'b1;
    for (int k = 0; k < 16; k++) home_run(kinds[k % 8]);
    // Codes without a method here are refused, never moved
    foreach (kinds[k]) begin
      rtype = k < 3 ? 4'(k + 1) : 4'(k + 8);
      pulse_start;
      check({terr, run}, 2'h2);
    end
    // Reset in mid-search drops coordinates until a new homing
    rtype = HPRS_TYPE_DOG;
    clr = 1'b1;
    pulse_start;
    clr = 1'b0;
    repeat (30) @(negedge clk_in);
    check(run, 1'b1);
    rstn_in = 1'b0;
    repeat (2) @(negedge clk_in);
    check({run, done, valid, terr, spd}, 20'h0);
    rstn_in = 1'b1;
    repeat (2) @(negedge clk_in);
    check({run, valid, done}, 3'h0);
    report_and_stop;
  end

  // Runs take about 10k cycles; this cuts a hang at 90k cycles
  initial begin
    #900000;
    err_total++;
    report_and_stop;
  end
endmodule // test_hprs_seq

// [verilog/hprs_pkg.sv]
// Purpose: Shared constants and types for the home return sequencer
// Assumes: 100 MHz clock, one position step pulse per unit of travel
// Notes: Method codes other than the dog method are local choices
package hprs_pkg;
  // Widths
  localparam int HPRS_POS_W = 32;
  localparam int HPRS_SPD_W = 16;
  localparam int HPRS_TC_W = 16;
  localparam int HPRS_TYPE_W = 4;
  localparam int HPRS_PSEL_W = 5;
  // Home return type codes
  localparam logic [3:0] HPRS_TYPE_DOG = 4'h0;
  localparam logic [3:0] HPRS_TYPE_COUNT = 4'h1;
  localparam logic [3:0] HPRS_TYPE_DATA_SET = 4'h2;
  localparam logic [3:0] HPRS_TYPE_STOPPER = 4'h3;
  localparam logic [3:0] HPRS_TYPE_IGNORE = 4'h4;
  localparam logic [3:0] HPRS_TYPE_REAR_END = 4'h5;
  localparam logic [3:0] HPRS_TYPE_CNT_FRONT = 4'h6;
  localparam logic [3:0] HPRS_TYPE_CRADLE = 4'h7;
  localparam logic [3:0] HPRS_TYPE_LAST_Z = 4'h8;
  localparam logic [3:0] HPRS_TYPE_FRONT_END = 4'h9;
  localparam logic [3:0] HPRS_TYPE_DOGLESS_Z = 4'hA;
  // Direction and polarity settings
  localparam logic HPRS_DIR_INC = 1'h0;
  localparam logic HPRS_DIR_DEC = 1'h1;
  localparam logic HPRS_POL_OFF_DET = 1'h0;
  localparam logic HPRS_POL_ON_DET = 1'h1;
  // Reset values
  localparam logic [31:0] HPRS_POS_RST = 32'h0000_0000;
  localparam logic [15:0] HPRS_SPD_RST = 16'h0000;
  localparam logic [2:0] HPRS_SYNC_RST = 3'h0;
  // Cycles after reset before the pin filter holds a settled level
  localparam logic [2:0] HPRS_SENSE_WARM = 3'h4;

  typedef enum logic [2:0] {
    HPRS_IDLE, HPRS_FAST, HPRS_CREEP, HPRS_REVERSE, HPRS_ZWAIT, HPRS_SHIFT
  } hprs_state_t;
endpackage

// [verilog/hprs_sense.sv]
// Purpose: Synchronises the dog and Z-phase pins and applies dog polarity
// Assumes: Pins are asynchronous to clk_in
// Notes: A change counts once the second and third stages agree
`timescale 1ns/1ns
module hprs_sense
  import hprs_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Pins
  input wire logic dog_pin_in,
  input wire logic zphase_pin_in,
  // Conditioned sense
  hprs_sense_if.cond sense
);
  typedef struct packed {
    logic [2:0] dog_sync;
    logic [2:0] z_sync;
    logic dog_level;
    logic z_level;
    logic dog_det;
    logic z_pulse;
    logic [2:0] warm;
  } hprs_sense_st_t;

  hprs_sense_st_t st_reg;
  hprs_sense_st_t st_next;

  // Filter: the first stage feeds only the second stage
  always_comb begin
    st_next = st_reg;
    st_next.dog_sync = {st_reg.dog_sync[1:0], dog_pin_in};
    st_next.z_sync = {st_reg.z_sync[1:0], zphase_pin_in};
    if (st_reg.dog_sync[1] == st_reg.dog_sync[2]) begin
      st_next.dog_level = st_reg.dog_sync[2];
    end
    if (st_reg.z_sync[1] == st_reg.z_sync[2]) begin
      st_next.z_level = st_reg.z_sync[2];
    end
    // Off-detect polarity inverts the pin sense
    st_next.dog_det = (sense.dog_polarity == HPRS_POL_ON_DET) ? st_reg.dog_level
                                                             : ~st_reg.dog_level;
    st_next.z_pulse = st_reg.z_level & ~st_next.z_level ? 1'b0
                                                        : (~st_reg.z_level & st_next.z_level);
    // Sense reads idle until the filter is filled; the reset level is not the pin's,
    // so a start right after reset would otherwise see a false dog or Z edge
    if (st_reg.warm != HPRS_SENSE_WARM) begin
      st_next.warm = st_reg.warm + 3'h1;
      st_next.dog_det = 1'b0;
      st_next.z_pulse = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sense.dog_det = st_reg.dog_det;
  assign sense.z_pulse = st_reg.z_pulse;

  // Assertions
  AST_DOG_POLARITY: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $past(rstn_in) |-> (st_reg.dog_det == (($past(st_reg.warm) != HPRS_SENSE_WARM) ? 1'b0
      : ($past(sense.dog_polarity) ? $past(st_reg.dog_level) : ~$past(st_reg.dog_level)))))
    else $error("dog detect does not follow polarity setting");
endmodule // hprs_sense

// [verilog/hprs_sense_if.sv]
// Purpose: Carries conditioned dog and Z-phase sense between modules
// Assumes: Single clock domain
// Notes: dog_det is a level, z_pulse is a one-cycle pulse
`timescale 1ns/1ns
interface hprs_sense_if;
  logic dog_polarity;
  logic dog_det;
  logic z_pulse;
  modport cond (input dog_polarity, output dog_det, output z_pulse);
  modport seq (output dog_polarity, input dog_det, input z_pulse);
endinterface : hprs_sense_if

// [verilog/hprs_seq.sv]
// Purpose: Home position return sequencer, top level
// Assumes: step_in pulses once per unit of travel in the commanded direction
// Notes: Count, data set and stopper methods are refused with an error flag
`timescale 1ns/1ns
module hprs_seq
  import hprs_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Mode selection and start
  input wire logic operation_mode_select_line_in,
  input wire logic [HPRS_PSEL_W-1:0] point_select_lines_in,
  input wire logic start_in,
  input wire logic servo_on_in,
  // Settings
  input wire logic [HPRS_TYPE_W-1:0] home_return_type_setting_in,
  input wire logic home_return_dir_setting_in,
  input wire logic dog_polarity_setting_in,
  input wire logic [HPRS_SPD_W-1:0] home_return_speed_setting_in,
  input wire logic [HPRS_SPD_W-1:0] creep_speed_setting_in,
  input wire logic [HPRS_POS_W-1:0] home_shift_distance_setting_in,
  input wire logic [HPRS_POS_W-1:0] post_dog_travel_setting_in,
  input wire logic [HPRS_POS_W-1:0] home_position_data_setting_in,
  input wire logic [HPRS_TC_W-1:0] pt1_accel_time_in,
  input wire logic [HPRS_TC_W-1:0] pt1_decel_time_in,
  // Pins and motion feedback
  input wire logic dog_pin_in,
  input wire logic zphase_pin_in,
  input wire logic step_in,
  // Motion command
  output logic run_out,
  output logic dir_dec_out,
  output logic [HPRS_SPD_W-1:0] speed_out,
  output logic [HPRS_TC_W-1:0] accel_time_out,
  output logic [HPRS_TC_W-1:0] decel_time_out,
  // Status
  output logic [HPRS_POS_W-1:0] current_position_out,
  output logic home_complete_out,
  output logic coord_valid_out,
  output logic type_error_out
);
  typedef struct packed {
    hprs_state_t state;
    logic [HPRS_TYPE_W-1:0] htype;
    logic start_d;
    logic servo_on_d;
    logic run;
    logic dir_dec;
    logic [HPRS_SPD_W-1:0] speed;
    logic [HPRS_TC_W-1:0] accel;
    logic [HPRS_TC_W-1:0] decel;
    logic [HPRS_POS_W-1:0] pos;
    logic [HPRS_POS_W-1:0] remain;
    logic done;
    logic valid;
    logic err;
  } hprs_st_t;

  hprs_st_t st_reg;
  hprs_st_t st_next;
  hprs_sense_if sense();

  // Pin conditioning
  hprs_sense u_sense (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .dog_pin_in(dog_pin_in),
    .zphase_pin_in(zphase_pin_in),
    .sense(sense.cond)
  );
  assign sense.dog_polarity = dog_polarity_setting_in;

  logic mode_ok;
  logic start_req;
  logic servo_rise;
  assign mode_ok = operation_mode_select_line_in && (point_select_lines_in == '0);
  assign start_req = start_in && !st_reg.start_d && mode_ok;
  assign servo_rise = servo_on_in && !st_reg.servo_on_d;

  // Finish: home position is set and coordinates become valid
  function automatic hprs_st_t finish(input hprs_st_t s, input logic [HPRS_POS_W-1:0] hp);
    hprs_st_t r;
    r = s;
    r.state = HPRS_IDLE;
    r.run = 1'b0;
    r.speed = HPRS_SPD_RST;
    r.pos = hp;
    r.done = 1'b1;
    r.valid = 1'b1;
    return r;
  endfunction

  // Enter shift phase, or finish at once when no distance is left
  function automatic hprs_st_t to_shift(input hprs_st_t s, input logic [HPRS_POS_W-1:0] d,
                                        input logic [HPRS_POS_W-1:0] hp);
    hprs_st_t r;
    r = s;
    if (d == '0) begin
      r = finish(s, hp);
    end else begin
      r.state = HPRS_SHIFT;
      r.remain = d;
    end
    return r;
  endfunction

  logic [HPRS_POS_W-1:0] travel_shift;
  assign travel_shift = post_dog_travel_setting_in + home_shift_distance_setting_in;

  // Sequencer
  always_comb begin
    st_next = st_reg;
    st_next.start_d = start_in;
    st_next.servo_on_d = servo_on_in;
    // Position tracks motion steps while moving
    if (st_reg.run && step_in) begin
      st_next.pos = st_reg.dir_dec ? st_reg.pos - 32'h0000_0001 : st_reg.pos + 32'h0000_0001;
    end
    unique case (st_reg.state)
      HPRS_IDLE: begin
        if (start_req) begin
          st_next.done = 1'b0;
          st_next.err = 1'b0;
          st_next.htype = home_return_type_setting_in;
          st_next.dir_dec = home_return_dir_setting_in;
          st_next.accel = pt1_accel_time_in;
          st_next.decel = pt1_decel_time_in;
          st_next.speed = home_return_speed_setting_in;
          st_next.run = 1'b1;
          st_next.state = HPRS_FAST;
          unique case (home_return_type_setting_in)
            HPRS_TYPE_IGNORE: begin
              // Servo-on position is kept, no motion
              st_next.run = 1'b0;
              st_next.speed = HPRS_SPD_RST;
              st_next.state = HPRS_IDLE;
              if (servo_on_in) begin
                st_next = finish(st_next, home_position_data_setting_in);
              end
            end
            HPRS_TYPE_DOGLESS_Z: begin
              st_next.speed = creep_speed_setting_in;
              st_next.state = HPRS_ZWAIT;
            end
            HPRS_TYPE_DOG, HPRS_TYPE_REAR_END, HPRS_TYPE_CNT_FRONT, HPRS_TYPE_CRADLE,
            HPRS_TYPE_LAST_Z, HPRS_TYPE_FRONT_END: begin
              st_next.state = HPRS_FAST;
            end
            default: begin
              // Count, data set and stopper are refused with the error flag
              st_next.run = 1'b0;
              st_next.speed = HPRS_SPD_RST;
              st_next.state = HPRS_IDLE;
              st_next.err = 1'b1;
            end
          endcase
        end else if (servo_rise && st_reg.htype == HPRS_TYPE_IGNORE && st_reg.err == 1'b0
                     && mode_ok && !st_reg.done) begin
          st_next = finish(st_next, home_position_data_setting_in);
        end
      end
      HPRS_FAST: begin
        if (sense.dog_det) begin
          st_next.speed = creep_speed_setting_in;
          unique case (st_reg.htype)
            HPRS_TYPE_CRADLE: st_next.state = HPRS_ZWAIT;
            HPRS_TYPE_LAST_Z: begin
              st_next.dir_dec = ~st_reg.dir_dec;
              st_next.state = HPRS_REVERSE;
            end
            HPRS_TYPE_CNT_FRONT, HPRS_TYPE_FRONT_END: begin
              st_next = to_shift(st_next, travel_shift, home_position_data_setting_in);
            end
            default: st_next.state = HPRS_CREEP;
          endcase
        end
      end
      HPRS_CREEP: begin
        // Waiting for the dog rear end
        if (!sense.dog_det) begin
          if (st_reg.htype == HPRS_TYPE_REAR_END) begin
            st_next = to_shift(st_next, travel_shift, home_position_data_setting_in);
          end else begin
            st_next.state = HPRS_ZWAIT;
          end
        end
      end
      HPRS_REVERSE: begin
        if (!sense.dog_det) begin
          st_next.state = HPRS_ZWAIT;
        end
      end
      HPRS_ZWAIT: begin
        if (sense.z_pulse) begin
          if (st_reg.htype == HPRS_TYPE_CRADLE) begin
            st_next = finish(st_next, home_position_data_setting_in);
          end else begin
            st_next = to_shift(st_next, home_shift_distance_setting_in,
                               home_position_data_setting_in);
          end
        end
      end
      HPRS_SHIFT: begin
        // Z-phase is ignored here; only distance counts
        if (step_in) begin
          if (st_reg.remain == 32'h0000_0001) begin
            st_next = finish(st_next, home_position_data_setting_in);
          end else begin
            st_next.remain = st_reg.remain - 32'h0000_0001;
          end
        end
      end
    endcase
  end

  // State register; power-up reset leaves coordinates invalid
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      st_reg <= '0;
      st_reg.state <= HPRS_IDLE;
      st_reg.valid <= 1'b0;
      st_reg.pos <= HPRS_POS_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign run_out = st_reg.run;
  assign dir_dec_out = st_reg.dir_dec;
  assign speed_out = st_reg.speed;
  assign accel_time_out = st_reg.accel;
  assign decel_time_out = st_reg.decel;
  assign current_position_out = st_reg.pos;
  assign home_complete_out = st_reg.done;
  assign coord_valid_out = st_reg.valid;
  assign type_error_out = st_reg.err;

  // Assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  AST_DIR_START: assert property (start_req && st_reg.state == HPRS_IDLE
    && home_return_type_setting_in == HPRS_TYPE_DOG
    |=> dir_dec_out == $past(home_return_dir_setting_in) && run_out)
    else $error("start direction does not follow setting");
  AST_DOG_CODE: assert property (start_req && st_reg.state == HPRS_IDLE
    && home_return_type_setting_in == HPRS_TYPE_DOG |=> st_reg.state == HPRS_FAST)
    else $error("dog code does not start search");
  AST_FAST_SPEED: assert property (st_reg.state == HPRS_FAST
    |-> speed_out == $past(home_return_speed_setting_in, 1) || $past(st_reg.state) == HPRS_FAST)
    else $error("search speed not taken from home speed setting");
  AST_CREEP_AFTER_DOG: assert property (st_reg.state == HPRS_FAST && sense.dog_det
    |=> speed_out == $past(creep_speed_setting_in) || home_complete_out)
    else $error("creep speed not applied after dog");
  AST_PT1_TIMES: assert property (start_req && st_reg.state == HPRS_IDLE
    |=> accel_time_out == $past(pt1_accel_time_in) && decel_time_out == $past(pt1_decel_time_in))
    else $error("time constants not from point table 1");
  AST_LOAD_HOME: assert property ($rose(home_complete_out)
    |-> current_position_out == $past(home_position_data_setting_in) && coord_valid_out)
    else $error("home data not loaded on completion");
  AST_VALID_RESET: assert property ($past(!rstn_in) |-> !coord_valid_out)
    else $error("coordinates valid right after reset");
  AST_DONE_CLEAR: assert property (start_req && st_reg.state == HPRS_IDLE
    && home_return_type_setting_in != HPRS_TYPE_IGNORE |=> !home_complete_out)
    else $error("complete flag not cleared at start");
  AST_MODE_GATE: assert property (st_reg.state == HPRS_IDLE && !mode_ok |=> !run_out)
    else $error("motion started outside home return mode");
  AST_LASTZ_REVERSE: assert property (st_reg.state == HPRS_FAST && sense.dog_det
    && st_reg.htype == HPRS_TYPE_LAST_Z |=> dir_dec_out != $past(dir_dec_out)
    ##0 st_reg.state == HPRS_REVERSE)
    else $error("last Z method did not reverse");
  AST_CRADLE_Z: assert property (st_reg.state == HPRS_ZWAIT && sense.z_pulse
    && st_reg.htype == HPRS_TYPE_CRADLE |=> home_complete_out && !run_out)
    else $error("cradle method did not finish on Z");
  AST_SHIFT_NO_Z: assert property (st_reg.state == HPRS_SHIFT && !step_in
    |=> st_reg.state == HPRS_SHIFT)
    else $error("shift phase left without travel");
endmodule // hprs_seq
